// ---- src/bpm_cfg.svh ----
/*
 * Constants of the bridge protection and mode control block.
 * Assumes a 25 MHz clock and a software view at byte offsets.
 */
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH
`define BPM_CLK_MHZ        25
`define BPM_CNT_W          17
`define BPM_OCP_FILTER_NS  4500
`define BPM_SHUNT_FILT_NS  4000
`define BPM_RETRY_US       4000
`define BPM_BLANK_CYC      25
`define BPM_HALL_IGN_CYC   50
`define BPM_SLEEP_CYC      2500
`define BPM_WAKE_CYC       2500
`define BPM_RSTWIN_CYC     500
`define BPM_DRIVE_CYC      100
`define BPM_TRIP_TIED      3'h6
`define BPM_CTRL_ADDR      8'h00
`define BPM_STATUS_ADDR    8'h04
`define BPM_SETTING_ADDR   8'h08
`define BPM_CTRL_INHIBIT   0
`define BPM_CTRL_RST       32'h0000_0000
`endif

// ---- src/bpm_ctrl.sv ----
/*
 * Bridge protection and mode control: current limit, hall
 * deglitch and tacho, fault handling, sleep/wake and APB view.
 * Assumes all inputs synchronous to ref_clk; comparators and
 * seven-level decoders are analog front ends outside.
 */
`timescale 1ns/10ps
`include "bpm_cfg.svh"
module bpm_ctrl #(
    parameter int RETRY_CYC = `BPM_RETRY_US * `BPM_CLK_MHZ,
    parameter int BLANK_CYC = `BPM_BLANK_CYC,
    parameter int HALL_CYC  = `BPM_HALL_IGN_CYC,
    parameter int SLEEP_CYC = `BPM_SLEEP_CYC,
    parameter int WAKE_CYC  = `BPM_WAKE_CYC,
    parameter int RSTW_CYC  = `BPM_RSTWIN_CYC,
    parameter int DRIVE_CYC = `BPM_DRIVE_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        enable_in,
    input  wire logic        pwm_in,
    input  wire logic [2:0]  phase_high_cmd,
    input  wire logic [2:0]  phase_low_cmd,
    input  wire logic [2:0]  hall_in,
    input  wire logic        limit_cmp,
    input  wire logic        shunt_cmp,
    input  wire logic [5:0]  vds_cmp,
    input  wire logic [5:0]  gate_high_sense,
    input  wire logic        supply_lockout,
    input  wire logic        pump_undervoltage,
    input  wire logic        overtemp_shutdown,
    input  wire logic [2:0]  gate_current_select,
    input  wire logic [2:0]  trip_level_select,
    output logic      [2:0]  high_gate_out,
    output logic      [2:0]  low_gate_out,
    output logic             gate_hiz,
    output logic             gate_weak_pull,
    output logic             pump_enable,
    output logic             regulator_enable,
    output logic      [2:0]  gate_current_level,
    output logic             fault_out_n_o,
    output logic             fault_out_n_oe,
    output logic             tacho_pulse_out_o,
    output logic             tacho_pulse_out_oe
);
    localparam int W = `BPM_CNT_W;
    localparam int OCP_CYC = (`BPM_OCP_FILTER_NS * `BPM_CLK_MHZ
                              + 999) / 1000;
    localparam int SHT_CYC = (`BPM_SHUNT_FILT_NS * `BPM_CLK_MHZ
                              + 999) / 1000;
    localparam logic [W-1:0] ONE = W'(1);

    bpm_pkg::bpm_state_type s_q;
    bpm_pkg::bpm_state_type s_d;

    logic       active;
    logic       drive_ok;
    logic       switch_hit;
    logic       wr_en;
    logic [5:0] gate_on;

    // ========================================================
    // gate outputs
    // ========================================================
    assign active   = s_q.mode == bpm_pkg::BPM_RUN ||
                      s_q.mode == bpm_pkg::BPM_DOWN;
    assign drive_ok = active && !pump_undervoltage
                      && !overtemp_shutdown && !s_q.retry
                      && !s_q.gate_fault && !s_q.inhibit;

    always_comb begin
        high_gate_out = 3'h0;
        low_gate_out  = 3'h0;
        if (drive_ok) begin
            high_gate_out = s_q.climit ? 3'h0 : phase_high_cmd;
            low_gate_out  = phase_low_cmd
                | (s_q.climit ? phase_high_cmd : 3'h0);
        end
    end
    assign gate_on = {high_gate_out, low_gate_out};

    assign gate_hiz       = active && !drive_ok;
    assign gate_weak_pull = s_q.mode == bpm_pkg::BPM_SLEEP ||
                            s_q.mode == bpm_pkg::BPM_LOCK;
    assign pump_enable    = (active || s_q.mode == bpm_pkg::BPM_WAKE)
                            && !overtemp_shutdown;
    assign regulator_enable = s_q.mode != bpm_pkg::BPM_SLEEP;
    assign gate_current_level = s_q.igs;

    // fault line drives low; released in sleep, early in down and in run without a fault
    assign fault_out_n_o  = 1'b0;
    assign fault_out_n_oe = s_q.mode == bpm_pkg::BPM_LOCK
        || s_q.mode == bpm_pkg::BPM_WAKE
        || (s_q.mode == bpm_pkg::BPM_DOWN
            && s_q.tcnt >= W'(RSTW_CYC))
        || (active && (pump_undervoltage || overtemp_shutdown
            || s_q.retry || s_q.gate_fault));

    assign tacho_pulse_out_o  = 1'b0;
    assign tacho_pulse_out_oe = !(^s_q.hall);

    assign switch_hit = |(vds_cmp & gate_on)
                        && s_q.trip != `BPM_TRIP_TIED;

    // ========================================================
    // apb
    // ========================================================
    assign pready  = 1'b1;
    assign prdata  = s_q.prdata;
    assign pslverr = psel && penable &&
                     paddr != `BPM_CTRL_ADDR &&
                     paddr != `BPM_STATUS_ADDR &&
                     paddr != `BPM_SETTING_ADDR;
    assign wr_en = psel && penable && pwrite &&
                   paddr == `BPM_CTRL_ADDR;

    // ========================================================
    // next state
    // ========================================================
    always_comb begin
        s_d = s_q;
        s_d.pwm = pwm_in;

        // current limit, cleared at each new pwm period
        if (pwm_in && !s_q.pwm) begin
            s_d.climit = 1'b0;
            s_d.blank  = W'(BLANK_CYC);
        end else begin
            if (s_q.blank != '0)
                s_d.blank = s_q.blank - ONE;
            if (s_q.blank == '0 && pwm_in && limit_cmp)
                s_d.climit = 1'b1;
        end

        // hall deglitch
        if (s_q.hign != '0) begin
            s_d.hign = s_q.hign - ONE;
        end else if (hall_in != s_q.hall) begin
            s_d.hall = hall_in;
            s_d.hign = W'(HALL_CYC);
        end

        // gate drive supervision, restarted by each command
        if (gate_on != s_q.cmd) begin
            s_d.cmd = gate_on;
            s_d.drv = W'(DRIVE_CYC);
        end else if (s_q.drv != '0) begin
            s_d.drv = s_q.drv - ONE;
            if (s_q.drv == ONE && drive_ok &&
                gate_high_sense != s_q.cmd)
                s_d.gate_fault = 1'b1;
        end

        // overcurrent filters and retry
        s_d.ocp   = (switch_hit && active) ? s_q.ocp + ONE : '0;
        s_d.shunt = (shunt_cmp && active) ? s_q.shunt + ONE : '0;
        if (s_q.retry) begin
            s_d.ocp   = '0;
            s_d.shunt = '0;
            s_d.retry_cnt = s_q.retry_cnt - ONE;
            if (s_q.retry_cnt == ONE)
                s_d.retry = 1'b0;
        end else if (s_q.ocp == W'(OCP_CYC - 1) ||
                     s_q.shunt == W'(SHT_CYC - 1)) begin
            s_d.retry     = 1'b1;
            s_d.retry_cnt = W'(RETRY_CYC);
        end

        // operating modes
        s_d.tcnt = s_q.tcnt + ONE;
        unique case (s_q.mode)
            bpm_pkg::BPM_LOCK: begin
                s_d.tcnt = '0;
                if (!supply_lockout)
                    s_d.mode = enable_in ? bpm_pkg::BPM_WAKE
                                         : bpm_pkg::BPM_SLEEP;
            end
            bpm_pkg::BPM_SLEEP: begin
                s_d.tcnt = '0;
                if (enable_in)
                    s_d.mode = bpm_pkg::BPM_WAKE;
            end
            bpm_pkg::BPM_WAKE: begin
                s_d.igs  = gate_current_select;
                s_d.trip = trip_level_select;
                s_d.gate_fault  = 1'b0;
                if (s_q.tcnt == W'(WAKE_CYC - 1))
                    s_d.mode = bpm_pkg::BPM_RUN;
            end
            bpm_pkg::BPM_RUN: begin
                s_d.tcnt = '0;
                if (!enable_in)
                    s_d.mode = bpm_pkg::BPM_DOWN;
            end
            bpm_pkg::BPM_DOWN: begin
                if (enable_in && s_q.tcnt < W'(RSTW_CYC)) begin
                    // a gate fault raised in this very cycle survives
                    s_d.gate_fault  = s_d.gate_fault && !s_q.gate_fault;
                    s_d.mode = bpm_pkg::BPM_RUN;
                end else if (s_q.tcnt == W'(SLEEP_CYC - 1)) begin
                    s_d.mode = bpm_pkg::BPM_SLEEP;
                end
            end
        endcase
        if (s_d.mode == bpm_pkg::BPM_WAKE &&
            s_q.mode != bpm_pkg::BPM_WAKE)
            s_d.tcnt = '0;

        // supply lockout overrides the mode and clears retry and gate fault
        if (supply_lockout) begin
            s_d.mode  = bpm_pkg::BPM_LOCK;
            s_d.retry = 1'b0;
            s_d.gate_fault   = 1'b0;
        end

        // register access
        if (wr_en)
            s_d.inhibit = pwdata[`BPM_CTRL_INHIBIT];
        if (psel && !penable) begin
            unique case (paddr)
                `BPM_CTRL_ADDR:
                    s_d.prdata = {31'h0000_0000, s_q.inhibit};
                `BPM_STATUS_ADDR:
                    s_d.prdata = {21'h00_0000, s_q.mode, s_q.climit,
                                  s_q.retry, s_q.gate_fault, supply_lockout,
                                  pump_undervoltage,
                                  overtemp_shutdown, s_q.hall == 3'h0,
                                  !fault_out_n_oe};
                `BPM_SETTING_ADDR:
                    s_d.prdata = {23'h00_0000, s_q.hall, s_q.trip,
                                  s_q.igs};
                default:
                    s_d.prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.inhibit <= 1'(`BPM_CTRL_RST);
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================================
    // checks
    // ========================================================
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence pwm_rise_s;
        !pwm_in ##1 pwm_in;
    endsequence

    property new_period_p;
        pwm_rise_s |=> !s_q.climit;
    endproperty

    limit_period_clear_a: assert property (new_period_p)
        else $error("current limit not cleared at pwm rise");
    blank_window_a: assert property (
        pwm_rise_s ##1 limit_cmp |=> !s_q.climit)
        else $error("limit tripped inside blanking");
    limit_hs_off_a: assert property (
        s_q.climit |-> high_gate_out == 3'h0)
        else $error("high side on during current limit");
    limit_ls_on_a: assert property (
        s_q.climit && drive_ok
        |-> (low_gate_out & phase_high_cmd) == phase_high_cmd)
        else $error("low side off during current limit");
    hall_ignore_a: assert property (
        s_q.hign != '0 |=> $stable(s_q.hall))
        else $error("hall edge taken inside ignore time");
    lockout_off_a: assert property (
        supply_lockout |=> fault_out_n_oe && gate_weak_pull
                           && !pump_enable)
        else $error("lockout response missing");
    retry_hold_a: assert property (
        $rose(s_q.retry) && active |-> gate_hiz [*2])
        else $error("gates driven during retry");
    gdf_latch_a: assert property (
        s_q.gate_fault && s_q.mode == bpm_pkg::BPM_RUN && enable_in
        && !supply_lockout |=> s_q.gate_fault)
        else $error("gate fault not latched");
    wake_fault_a: assert property (
        s_q.mode == bpm_pkg::BPM_WAKE |-> fault_out_n_oe)
        else $error("fault line released during wake");
    reset_pulse_a: assert property (
        s_q.mode == bpm_pkg::BPM_DOWN && enable_in && s_q.gate_fault
        && s_q.tcnt < W'(RSTW_CYC) && !supply_lockout |=>
        s_q.mode == bpm_pkg::BPM_RUN && !s_q.gate_fault)
        else $error("short enable pulse did not clear fault");
    sleep_off_a: assert property (
        s_q.mode == bpm_pkg::BPM_SLEEP
        |-> !regulator_enable && !pump_enable
            && high_gate_out == 3'h0)
        else $error("sleep left supplies on");
endmodule

// ---- src/bpm_pkg.sv ----
/*
 * Types of the bridge protection and mode control block.
 * Assumes bpm_cfg.svh for the counter width.
 */
`include "bpm_cfg.svh"
package bpm_pkg;
    typedef enum logic [2:0] {
        BPM_LOCK,
        BPM_SLEEP,
        BPM_WAKE,
        BPM_RUN,
        BPM_DOWN
    } bpm_mode_type;

    typedef logic [`BPM_CNT_W-1:0] bpm_cnt_type;

    typedef struct packed {
        bpm_mode_type mode;
        bpm_cnt_type  tcnt;
        bpm_cnt_type  blank;
        bpm_cnt_type  hign;
        bpm_cnt_type  drv;
        bpm_cnt_type  ocp;
        bpm_cnt_type  shunt;
        bpm_cnt_type  retry_cnt;
        logic         retry;
        logic         climit;
        logic         pwm;
        logic [2:0]   hall;
        logic [5:0]   cmd;
        logic         gate_fault;
        logic [2:0]   igs;
        logic [2:0]   trip;
        logic         inhibit;
        logic [31:0]  prdata;
    } bpm_state_type;
endpackage

// ---- test/bpm_ctrl_tb_top.sv ----
/*
 * Self-checking bench of bpm_ctrl with APB tasks.
 * Assumes bpm_mcu_model drives enable and pwm.
 */
`timescale 1ns/10ps
module bpm_ctrl_tb_top;
    logic        ref_clk = 0, rst = 1;
    logic        psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic        pready, pslverr, err, enable_in, pwm_in, ctl_ready;
    logic        en_req = 1, pulse_req = 0, duty_full = 1;
    logic [2:0]  phase_high_cmd = 0, phase_low_cmd = 0, hall_in = 0;
    logic        limit_cmp = 0, shunt_cmp = 0;
    logic [5:0]  vds_cmp = 0, gate_high_sense, gbreak = 0;
    logic        supply_lockout = 0, pump_undervoltage = 0;
    logic        overtemp_shutdown = 0;
    logic [2:0]  gate_current_select = 3'h2, trip_level_select = 3'h6;
    logic [2:0]  high_gate_out, low_gate_out, gate_current_level, h;
    logic        gate_hiz, gate_weak_pull, pump_enable, regulator_enable;
    logic        fault_out_n_o, fault_out_n_oe;
    logic        tacho_pulse_out_o, tacho_pulse_out_oe;
    int          fail_count = 0, n_compared = 0, seed = 32'h23c7;

    assign gate_high_sense = {high_gate_out, low_gate_out} ^ gbreak;
    always #20 ref_clk = ~ref_clk;

    bpm_mcu_model #(.WAKE_CYC(50), .PERIOD(100)) mcu (.ref_clk, .rst,
        .en_req, .pulse_req, .duty_full, .enable_in, .pwm_in, .ctl_ready);
    bpm_ctrl #(.RETRY_CYC(200), .SLEEP_CYC(50), .WAKE_CYC(50),
        .RSTW_CYC(10)) DUT (.ref_clk, .rst, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .enable_in, .pwm_in,
        .phase_high_cmd, .phase_low_cmd, .hall_in, .limit_cmp, .shunt_cmp,
        .vds_cmp, .gate_high_sense, .supply_lockout, .pump_undervoltage,
        .overtemp_shutdown, .gate_current_select, .trip_level_select,
        .high_gate_out, .low_gate_out, .gate_hiz, .gate_weak_pull,
        .pump_enable, .regulator_enable, .gate_current_level,
        .fault_out_n_o, .fault_out_n_oe, .tacho_pulse_out_o,
        .tacho_pulse_out_oe);

    // ==========================================
    // tasks
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        if (k >= 20) begin
            fail_count++;
            summarize();
        end
    endtask
    // waits for ready (0), pwm high (1) or pwm low (2)
    task automatic wait_w(input int w);
        int k;
        k = 0;
        while ((w == 0 ? ctl_ready : w == 1 ? pwm_in : !pwm_in) !== 1'b1
               && k < 500) begin
            @(posedge ref_clk);
            k++;
        end
        if (k >= 500) begin
            fail_count++;
            summarize();
        end
    endtask

    // ==========================================
    // main sequence
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        summarize();
    end
    initial begin
        cyc(8);
        rst <= 0;
        cyc(5);
        #1 chk("fault_wake", 1, fault_out_n_oe);
        wait_w(0);
        cyc(5);
        #1 chk("fault_run", 0, fault_out_n_oe);
        chk("pump_run", 1, pump_enable);
        chk("reg_run", 1, regulator_enable);
        chk("level", 2, gate_current_level);
        apb(0, 8'h04, 0);
        chk("mode_run", 3, rd[10:8]);
        apb(0, 8'h40, 0);
        chk("unmapped_err", 1, err);
        chk("unmapped_rd", 0, rd);
        phase_high_cmd <= 3'b001;
        gate_current_select <= 3'h5;
        apb(1, 8'h00, 1);
        apb(0, 8'h00, 0);
        chk("ctrl_rd", 1, rd);
        #1 chk("inhibit", 0, high_gate_out);
        apb(1, 8'h00, 0);
        cyc(2);
        #1 chk("high_on", 1, high_gate_out);
        chk("level_held", 2, gate_current_level);
        phase_low_cmd <= 3'b100;
        cyc(1);
        #1 chk("low_on", 4, low_gate_out);
        $display("test mode and registers done");
        vds_cmp <= 6'b001000;
        cyc(130);
        #1 chk("vds_tied", 0, fault_out_n_oe);
        cyc(1);
        vds_cmp <= 0;
        shunt_cmp <= 1;
        cyc(90);
        #1 chk("shunt_early", 0, gate_hiz);
        cyc(20);
        #1 chk("shunt_hiz", 1, gate_hiz);
        chk("shunt_fault", 1, fault_out_n_oe);
        cyc(1);
        shunt_cmp <= 0;
        cyc(150);
        #1 chk("shunt_retry", 1, gate_hiz);
        cyc(100);
        #1 chk("shunt_clear", 0, gate_hiz);
        $display("test overcurrent done");
        duty_full <= 0;
        wait_w(2);
        wait_w(1);
        limit_cmp <= 1;
        cyc(3);
        #1 chk("blank", 1, high_gate_out[0]);
        cyc(29);
        #1 chk("limit_high", 0, high_gate_out[0]);
        chk("limit_low", 1, low_gate_out[0]);
        cyc(1);
        limit_cmp <= 0;
        cyc(10);
        #1 chk("limit_hold", 0, high_gate_out[0]);
        wait_w(2);
        wait_w(1);
        cyc(3);
        #1 chk("limit_next", 1, high_gate_out[0]);
        $display("test current limit done");
        // hall lines stay low until here; eight random codes follow
        repeat (8) begin
            cyc(1);
            h = 3'($random(seed));
            hall_in <= h;
            cyc(60);
            #1 chk("tacho", ~^h, tacho_pulse_out_oe);
        end
        cyc(1);
        hall_in <= h ^ 3'b001;
        cyc(3);
        hall_in <= h ^ 3'b011;
        cyc(10);
        #1 chk("hall_ignore", ~^(h ^ 3'b001), tacho_pulse_out_oe);
        cyc(60);
        #1 chk("hall_late", ~^(h ^ 3'b011), tacho_pulse_out_oe);
        $display("test hall done");
        for (int i = 0; i < 3; i++) begin
            cyc(1);
            {supply_lockout, pump_undervoltage, overtemp_shutdown}
                <= 3'(1 << i);
            cyc(3);
            #1 chk("flt_fault", 1, fault_out_n_oe);
            chk("flt_gate", 0, high_gate_out);
            if (i != 1)
                chk("flt_pump", 0, pump_enable);
            if (i == 2)
                chk("flt_weak", 1, gate_weak_pull);
            cyc(1);
            {supply_lockout, pump_undervoltage, overtemp_shutdown} <= 0;
            cyc(70);
            #1 chk("flt_clear", 0, fault_out_n_oe);
        end
        $display("test supply faults done");
        cyc(1);
        duty_full <= 1;
        gbreak <= 6'b010000;
        phase_high_cmd <= 3'b010;
        cyc(120);
        #1 chk("gdf_fault", 1, fault_out_n_oe);
        chk("gdf_gate", 0, high_gate_out);
        cyc(1);
        gbreak <= 0;
        cyc(30);
        #1 chk("gdf_latched", 1, fault_out_n_oe);
        cyc(1);
        pulse_req <= 1;
        gate_current_select <= 3'h3;
        cyc(1);
        pulse_req <= 0;
        cyc(80);
        #1 chk("pulse_clear", 0, fault_out_n_oe);
        // lockout recovery above recaptured 5; the pulse must not recapture
        chk("pulse_level", 5, gate_current_level);
        chk("pulse_reg", 1, regulator_enable);
        apb(0, 8'h04, 0);
        chk("pulse_gdf", 0, rd[5]);
        $display("test gate fault done");
        cyc(1);
        en_req <= 0;
        cyc(15);
        #1 chk("down_fault", 1, fault_out_n_oe);
        cyc(60);
        #1 chk("sleep_pump", 0, pump_enable);
        chk("sleep_reg", 0, regulator_enable);
        chk("sleep_weak", 1, gate_weak_pull);
        chk("sleep_fault", 0, fault_out_n_oe);
        apb(0, 8'h04, 0);
        chk("mode_sleep", 1, rd[10:8]);
        cyc(1);
        trip_level_select <= 3'h2;
        en_req <= 1;
        wait_w(0);
        cyc(5);
        #1 chk("rewake_level", 3, gate_current_level);
        cyc(1);
        vds_cmp <= 6'b010000;
        cyc(130);
        #1 chk("vds_hiz", 1, gate_hiz);
        chk("vds_fault", 1, fault_out_n_oe);
        cyc(1);
        vds_cmp <= 0;
        cyc(150);
        #1 chk("vds_retry", 1, gate_hiz);
        cyc(100);
        #1 chk("vds_clear", 0, gate_hiz);
        apb(0, 8'h08, 0);
        chk("setting", {23'h00_0000, h ^ 3'b011, 3'h2, 3'h3}, rd);
        $display("test sleep and rewake done");
        summarize();
    end
endmodule

// ---- test/bpm_mcu_model.sv ----
/*
 * Controller-side model: drives the enable and pwm pins.
 * Assumes the bench asks for enable level, reset pulses and duty.
 */
`timescale 1ns/10ps
module bpm_mcu_model #(
    parameter int WAKE_CYC = 50,
    parameter int PERIOD   = 100
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic en_req,
    input  wire logic pulse_req,
    input  wire logic duty_full,
    output logic      enable_in,
    output logic      pwm_in,
    output logic      ctl_ready
);
    int wake_q;
    int per_q;
    int low_q;
    // controls stay quiet until the wake delay has run out
    assign ctl_ready = wake_q >= WAKE_CYC;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wake_q    <= 0;
            per_q     <= 0;
            low_q     <= 0;
            enable_in <= 1'b0;
            pwm_in    <= 1'b0;
        end else begin
            // three-cycle low phase, well inside the reset window
            if (pulse_req)
                low_q <= 3;
            else if (low_q != 0)
                low_q <= low_q - 1;
            enable_in <= en_req && !(pulse_req || low_q > 1);
            if (!enable_in)
                wake_q <= 0;
            else if (wake_q < WAKE_CYC)
                wake_q <= wake_q + 1;
            per_q  <= ctl_ready ? (per_q + 1) % PERIOD : 0;
            pwm_in <= ctl_ready && (duty_full || per_q < PERIOD / 2);
        end
    end
endmodule
